// ===== src/acspc_pkg.sv
// register map, field positions and divider counts for clock config
package acspc_pkg;
  localparam logic [7:0] CLOCK_SOURCE_CONFIG_OFS    = 8'h16;
  localparam logic [7:0] PDM_CLK_OFS    = 8'h1f;
  localparam logic [7:0] PDM_IN_OFS     = 8'h20;
  localparam logic [7:0] CLOCK_SOURCE_CONFIG_RST    = 8'h10;
  localparam logic [7:0] PDM_CLK_RST    = 8'h40;
  localparam logic [7:0] PDM_IN_RST     = 8'h00;
  localparam logic [7:0] PDM_IN_WMASK   = 8'hc0;
  localparam int         ROOT_SEL_BIT   = 7;
  localparam int         FREQ_MODE_BIT  = 6;
  localparam int         RATIO_MSB      = 5;
  localparam int         RATIO_LSB      = 3;
  localparam int         INV_BIT        = 1;
  localparam int         DIV_MSB        = 1;
  localparam int         EDGE_BIT       = 7;
  localparam logic [1:0] PDM_DIV_FAST   = 2'h3;
  // root clock edges per pdm half period, root assumed at 512 fs
  localparam logic [4:0] PDM_HALF_DIV0  = 5'h04;
  localparam logic [4:0] PDM_HALF_DIV1  = 5'h08;
  localparam logic [4:0] PDM_HALF_DIV2  = 5'h10;
  localparam logic [4:0] PDM_HALF_DIV3  = 5'h02;

  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic [7:0] wdata;
  } acspc_reg_req_s;
endpackage : acspc_pkg

// ===== src/acspc_clock_cfg.sv
// clock source selection, pdm clock divider and pdm edge latching
// What this block does
// R01: with auto config, slave mode and pll bypassed, bit 7 picks bclk (0) or mclk (1) as root.
// R02: when mclk is root in slave mode the mclk-to-frame_sync relation comes from the ratio field.
// R03: in auto config bit 6 picks the fixed frequency code (0) or the frame_sync ratio (1).
// R04: ratio field bits 5:3, reset 010b, maps codes 0..7 to 64,256,384,512,768,1024,1536,2304.
// R05: in master mode bit 1 inverts bclk only for frame sync generation.
// R06: software writes each single reserved bit with its reset value.
// R07: software writes pdm clock config bits 6:2 as 10000b.
// R08: the two-bit divider gives 3.072, 1.536, 0.768 or 6.144 MHz (44.1k family: 2.8224 etc).
// R09: the fastest pdm divider is only for channels one and two.
// R10: edge bit 7 latches channel one on falling and two on rising when 0, reversed when 1.
// R11: master mode drives bclk and frame sync, slave mode takes both as inputs.
// R12: with auto config, the auto pll bypass setting bypasses the pll when set; otherwise the pll is used.
// R13: the rate family input selects 48 kHz (0) or 44.1 kHz (1) as the pdm rate family.
// R14: pdm clock is an integer division of the root clock, near 50% duty, glitch free.
`timescale 1ns/1ns
module acspc_clock_cfg (
  input  wire logic                    core_clk,
  input  wire logic                    reset,
  input  wire acspc_pkg::acspc_reg_req_s regReq,
  output logic [7:0]                   regRdata,
  input  wire logic                    masterMode,
  input  wire logic                    autoCfgEnable,
  input  wire logic                    autoPllBypass,
  input  wire logic                    rateFamilySelect,
  input  wire logic                    chan34Active,
  input  wire logic                    bclkIn,
  input  wire logic                    mclkIn,
  input  wire logic                    pllClkIn,
  input  wire logic                    pdmDataIn,
  output logic                         rootFromMclk,
  output logic                         pllInUse,
  output logic                         refSpecRatio,
  output logic [11:0]                  mclkRatio,
  output logic                         fsyncGenBclk,
  output logic                         bclkOe,
  output logic                         fsyncOe,
  output logic                         rateFamily441,
  output logic                         pdmRateConflict,
  output logic                         pdmClockOut,
  output logic                         pdmCh1Bit,
  output logic                         pdmCh2Bit,
  output logic                         pdmCh1Strobe,
  output logic                         pdmCh2Strobe
);

  function automatic logic [11:0] ratioOf(input logic [2:0] code);
    case (code)
      3'h0:    ratioOf = 12'h040;
      3'h1:    ratioOf = 12'h100;
      3'h2:    ratioOf = 12'h180;
      3'h3:    ratioOf = 12'h200;
      3'h4:    ratioOf = 12'h300;
      3'h5:    ratioOf = 12'h400;
      3'h6:    ratioOf = 12'h600;
      default: ratioOf = 12'h900;
    endcase
  endfunction : ratioOf

  function automatic logic [4:0] halfLimit(input logic [1:0] div);
    case (div)
      2'h0:    halfLimit = acspc_pkg::PDM_HALF_DIV0;
      2'h1:    halfLimit = acspc_pkg::PDM_HALF_DIV1;
      2'h2:    halfLimit = acspc_pkg::PDM_HALF_DIV2;
      default: halfLimit = acspc_pkg::PDM_HALF_DIV3;
    endcase
  endfunction : halfLimit

  logic [7:0]  clkSrc_q;
  logic [7:0]  pdmClkCfg_q;
  logic [7:0]  pdmInCfg_q;
  logic [7:0]  rdata_q;
  logic        rootFromMclk_q;
  logic        pllInUse_q;
  logic        refSpecRatio_q;
  logic [11:0] mclkRatio_q;
  logic        fsyncGenBclk_q;
  logic        bclkOe_q;
  logic        fsyncOe_q;
  logic        family_q;
  logic        conflict_q;
  logic        rootLevel_q;
  logic        rootPrev_q;
  logic [4:0]  halfCnt_q;
  logic [1:0]  divActive_q;
  logic        pdm_clock_out_q;
  logic        ch1_q;
  logic        ch2_q;
  logic        ch1Stb_q;
  logic        ch2Stb_q;

  wire wrClkSrc = regReq.wr && regReq.addr == acspc_pkg::CLOCK_SOURCE_CONFIG_OFS;
  wire wrPdmClk = regReq.wr && regReq.addr == acspc_pkg::PDM_CLK_OFS;
  wire wrPdmIn  = regReq.wr && regReq.addr == acspc_pkg::PDM_IN_OFS;
  wire [7:0] rdMux =
    (regReq.addr == acspc_pkg::CLOCK_SOURCE_CONFIG_OFS) ? clkSrc_q :
    (regReq.addr == acspc_pkg::PDM_CLK_OFS) ? pdmClkCfg_q :
    (regReq.addr == acspc_pkg::PDM_IN_OFS)  ? pdmInCfg_q : 8'h00;

  wire bypassPll  = autoCfgEnable && autoPllBypass; // R12
  wire selMclk    = bypassPll && !masterMode
                    && clkSrc_q[acspc_pkg::ROOT_SEL_BIT]; // R01
  wire ratioMode  = selMclk // R02
                    || (autoCfgEnable
                        && clkSrc_q[acspc_pkg::FREQ_MODE_BIT]); // R03
  // pll output stands in as root whenever the pll is in use
  wire rootLevel  = !bypassPll ? pllClkIn : (selMclk ? mclkIn : bclkIn);
  wire rootRise   = rootLevel_q && !rootPrev_q;
  wire [1:0] divSel = pdmClkCfg_q[acspc_pkg::DIV_MSB:0];
  wire halfDone   = rootRise
                    && halfCnt_q == halfLimit(divActive_q) - 5'h01;
  wire goingHigh  = halfDone && !pdm_clock_out_q;
  wire edgeSel    = pdmInCfg_q[acspc_pkg::EDGE_BIT];
  wire capCh1     = halfDone && (goingHigh == edgeSel); // R10
  wire capCh2     = halfDone && (goingHigh != edgeSel); // R10

  always_ff @(posedge core_clk) begin
    if (reset) begin
      clkSrc_q    <= acspc_pkg::CLOCK_SOURCE_CONFIG_RST;
      pdmClkCfg_q <= acspc_pkg::PDM_CLK_RST;
      pdmInCfg_q  <= acspc_pkg::PDM_IN_RST;
      rdata_q     <= 8'h00;
    end else begin
      // reserved bits of clock source and pdm clock config are stored as written; pdm input config keeps only bits 7:6
      if (wrClkSrc) clkSrc_q <= regReq.wdata; // R06
      if (wrPdmClk) pdmClkCfg_q <= regReq.wdata; // R07
      if (wrPdmIn) pdmInCfg_q <= regReq.wdata & acspc_pkg::PDM_IN_WMASK;
      rdata_q <= rdMux;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      rootFromMclk_q <= 1'b0;
      pllInUse_q     <= 1'b1;
      refSpecRatio_q <= 1'b0;
      mclkRatio_q    <= 12'h180;
      fsyncGenBclk_q <= 1'b0;
      bclkOe_q       <= 1'b0;
      fsyncOe_q      <= 1'b0;
      family_q       <= 1'b0;
      conflict_q     <= 1'b0;
    end else begin
      rootFromMclk_q <= selMclk; // R01
      pllInUse_q     <= !bypassPll; // R12
      refSpecRatio_q <= ratioMode; // R03
      mclkRatio_q    <= ratioOf(clkSrc_q[acspc_pkg::RATIO_MSB:
                                         acspc_pkg::RATIO_LSB]); // R04
      fsyncGenBclk_q <= bclkIn ^ (masterMode
                                  && clkSrc_q[acspc_pkg::INV_BIT]); // R05
      bclkOe_q       <= masterMode; // R11
      fsyncOe_q      <= masterMode; // R11
      family_q       <= rateFamilySelect; // R13
      // fast divider with channels 3/4 is flagged, not blocked
      conflict_q     <= divSel == acspc_pkg::PDM_DIV_FAST
                        && chan34Active; // R09
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      rootLevel_q <= 1'b0;
      rootPrev_q  <= 1'b0;
      halfCnt_q   <= 5'h00;
      divActive_q <= 2'h0;
      pdm_clock_out_q    <= 1'b0;
    end else begin
      rootLevel_q <= rootLevel;
      rootPrev_q  <= rootLevel_q;
      if (halfDone) begin
        halfCnt_q <= 5'h00;
        pdm_clock_out_q  <= !pdm_clock_out_q; // R14
        // new divider only at a falling edge so no runt pulse appears
        if (pdm_clock_out_q) divActive_q <= divSel; // R08
      end else if (rootRise) begin
        halfCnt_q <= halfCnt_q + 5'h01; // R14
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      ch1_q    <= 1'b0;
      ch2_q    <= 1'b0;
      ch1Stb_q <= 1'b0;
      ch2Stb_q <= 1'b0;
    end else begin
      if (capCh1) ch1_q <= pdmDataIn; // R10
      if (capCh2) ch2_q <= pdmDataIn; // R10
      ch1Stb_q <= capCh1;
      ch2Stb_q <= capCh2;
    end
  end

  assign regRdata        = rdata_q;
  assign rootFromMclk    = rootFromMclk_q;
  assign pllInUse        = pllInUse_q;
  assign refSpecRatio    = refSpecRatio_q;
  assign mclkRatio       = mclkRatio_q;
  assign fsyncGenBclk    = fsyncGenBclk_q;
  assign bclkOe          = bclkOe_q;
  assign fsyncOe         = fsyncOe_q;
  assign rateFamily441   = family_q;
  assign pdmRateConflict = conflict_q;
  assign pdmClockOut     = pdm_clock_out_q;
  assign pdmCh1Bit       = ch1_q;
  assign pdmCh2Bit       = ch2_q;
  assign pdmCh1Strobe    = ch1Stb_q;
  assign pdmCh2Strobe    = ch2Stb_q;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  root_src_sel_a: assert property ( // R01
    bypassPll && !masterMode |=>
      rootFromMclk_q == $past(clkSrc_q[acspc_pkg::ROOT_SEL_BIT]))
    else $error("root source does not follow select bit");
  mclk_ratio_use_a: assert property ( // R02
    rootFromMclk_q |-> refSpecRatio_q)
    else $error("mclk root without ratio mode");
  freq_mode_a: assert property ( // R03
    autoCfgEnable |=>
      refSpecRatio_q == ($past(clkSrc_q[acspc_pkg::FREQ_MODE_BIT])
                         || $past(selMclk)))
    else $error("frequency spec mode wrong");
  ratio_top_a: assert property ( // R04
    clkSrc_q[5:3] == 3'h7 ##1 clkSrc_q[5:3] == 3'h7 |-> mclkRatio_q == 12'h900)
    else $error("ratio code 7 not 2304");
  frame_sync_no_inv_a: assert property ( // R05
    !masterMode |=> fsyncGenBclk_q == $past(bclkIn))
    else $error("bclk inverted outside master mode");
  pdm_half_cnt_a: assert property ( // R08
    halfCnt_q < halfLimit(divActive_q))
    else $error("pdm half period counter overran");
  edge_sel_a: assert property ( // R10
    ch1Stb_q |-> pdm_clock_out_q == $past(edgeSel))
    else $error("channel one latched on wrong edge");
  drive_dir_a: assert property ( // R11
    $past(masterMode) == masterMode |=>
      bclkOe_q == $past(masterMode) && fsyncOe_q == $past(masterMode))
    else $error("drive enables do not follow mode");
  pll_bypass_a: assert property ( // R12
    ##1 pllInUse_q == !$past(autoCfgEnable && autoPllBypass))
    else $error("pll use does not follow bypass");
  div_glitch_a: assert property ( // R14
    $changed(divActive_q) |-> !pdm_clock_out_q)
    else $error("divider changed while pdm clock high");

endmodule : acspc_clock_cfg

// ===== verification/acspc_pdm_mic.sv
// pdm microphone and audio clock source model
`timescale 1ns/1ns
module acspc_pdm_mic (
  input  wire logic core_clk,
  input  wire logic run,
  input  wire logic pdm_clock_out,
  output logic      rootClk,
  output logic      pdmData
);
  // root clock stands still outside frames
  always_ff @(posedge core_clk) begin
    rootClk <= run & (rootClk !== 1'b1);
    // low half carries 0, high half 1
    pdmData <= pdm_clock_out;
  end
endmodule : acspc_pdm_mic

// ===== verification/acspc_clock_cfg_tb.sv
// self-checking bench for the clock configuration block
`timescale 1ns/1ns
module acspc_clock_cfg_tb;
  localparam logic [11:0] RATIO [8] = '{12'h040, 12'h100, 12'h180,
    12'h200, 12'h300, 12'h400, 12'h600, 12'h900};
  localparam int HALF [4] = '{4, 8, 16, 2};
  acspc_pkg::acspc_reg_req_s regReq = '0;
  logic core_clk = 1'b0, reset = 1'b1, run = 1'b0;
  logic masterMode = 1'b0, autoCfgEnable = 1'b0, autoPllBypass = 1'b0;
  logic rateFamilySelect = 1'b0, chan34Active = 1'b0;
  logic rootClk, pdmData, rootFromMclk, pllInUse, refSpecRatio;
  logic fsyncGenBclk, bclkOe, fsyncOe, rateFamily441, pdmRateConflict;
  logic pdmClockOut, pdmCh1Bit, pdmCh2Bit, pdmCh1Strobe, pdmCh2Strobe;
  logic [7:0]  regRdata;
  logic [11:0] mclkRatio;
  int          bad_count = 0;
  int          tests_run = 0;

  always #25 core_clk = ~core_clk;

  acspc_clock_cfg u_acspc_clock_cfg (.core_clk(core_clk), .reset(reset),
    .regReq(regReq), .regRdata(regRdata), .masterMode(masterMode),
    .autoCfgEnable(autoCfgEnable), .autoPllBypass(autoPllBypass),
    .rateFamilySelect(rateFamilySelect), .chan34Active(chan34Active),
    .bclkIn(rootClk), .mclkIn(rootClk), .pllClkIn(rootClk),
    .pdmDataIn(pdmData), .rootFromMclk(rootFromMclk), .pllInUse(pllInUse),
    .refSpecRatio(refSpecRatio), .mclkRatio(mclkRatio),
    .fsyncGenBclk(fsyncGenBclk), .bclkOe(bclkOe), .fsyncOe(fsyncOe),
    .rateFamily441(rateFamily441), .pdmRateConflict(pdmRateConflict),
    .pdmClockOut(pdmClockOut), .pdmCh1Bit(pdmCh1Bit),
    .pdmCh2Bit(pdmCh2Bit), .pdmCh1Strobe(pdmCh1Strobe),
    .pdmCh2Strobe(pdmCh2Strobe));

  acspc_pdm_mic u_acspc_pdm_mic (.core_clk(core_clk), .run(run),
    .pdm_clock_out(pdmClockOut), .rootClk(rootClk), .pdmData(pdmData));

  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regReq <= '{addr: a, wr: 1'b1, wdata: d};
    @(posedge core_clk);
    regReq.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    regReq.addr <= a;
    tick(2);
    check(regRdata, exp);
  endtask : rd

  task automatic set(input logic m, input logic a, input logic b);
    @(posedge core_clk);
    masterMode <= m;
    autoCfgEnable <= a;
    autoPllBypass <= b;
    tick(3);
  endtask : set

  // counts cycles up to the next rising pdm clock, bounded
  task automatic rise(output int n);
    logic p;
    n = 1;
    p = pdmClockOut;
    tick(1);
    while (!(pdmClockOut === 1'b1 && p === 1'b0) && n < 300) begin
      p = pdmClockOut;
      tick(1);
      n++;
    end
  endtask : rise

  task automatic t_regs;
    rd(8'h16, 8'h10);
    rd(8'h1f, 8'h40);
    rd(8'h20, 8'h00);
    check(mclkRatio, 12'h180);
    check(rateFamily441, 1'b0);
    wr(8'h21, 8'hff);
    rd(8'h21, 8'h00);
    // reserved bits of the edge register only ever get their reset value
    wr(8'h20, 8'h80);
    rd(8'h20, 8'h80);
    for (int c = 0; c < 8; c++) begin
      wr(8'h16, {2'b00, c[2:0], 3'b000});
      tick(3);
      check(mclkRatio, RATIO[c]);
    end
  endtask : t_regs

  task automatic t_root;
    set(1'b0, 1'b1, 1'b1);
    wr(8'h16, 8'h80);
    tick(3);
    check(rootFromMclk, 1'b1);
    check(refSpecRatio, 1'b1);
    check(pllInUse, 1'b0);
    set(1'b1, 1'b1, 1'b1);
    check(rootFromMclk, 1'b0);
    check({bclkOe, fsyncOe}, 2'b11);
    wr(8'h16, 8'h40);
    set(1'b0, 1'b1, 1'b0);
    check({rootFromMclk, pllInUse, refSpecRatio, bclkOe}, 4'h6);
    wr(8'h16, 8'h00);
    tick(3);
    check(refSpecRatio, 1'b0);
  endtask : t_root

  // bit clock held low so only the invert shows
  task automatic t_inv;
    wr(8'h16, 8'h02);
    set(1'b1, 1'b0, 1'b0);
    check(fsyncGenBclk, 1'b1);
    set(1'b0, 1'b0, 1'b0);
    check(fsyncGenBclk, 1'b0);
    wr(8'h16, 8'h00);
    set(1'b1, 1'b0, 1'b0);
    check(fsyncGenBclk, 1'b0);
  endtask : t_inv

  task automatic t_pdm(input logic edgeSel);
    int n;
    wr(8'h20, {edgeSel, 7'h00});
    for (int c = 0; c < 4; c++) begin
      // channels 3/4 drop out before the fast divider goes in
      @(posedge core_clk);
      chan34Active <= 1'b0;
      wr(8'h1f, {6'h10, c[1:0]});
      @(posedge core_clk);
      chan34Active <= c != 3;
      // a new divider lands only at a falling toggle
      tick(150);
      rise(n);
      check({pdmCh1Strobe, pdmCh2Strobe}, {edgeSel, ~edgeSel});
      check({pdmCh1Bit, pdmCh2Bit}, {~edgeSel, edgeSel});
      check(pdmRateConflict, 1'b0);
      rise(n);
      check(12'(n), 12'(4 * HALF[c]));
    end
    check(rateFamily441, 1'b1);
  endtask : t_pdm

  task automatic stop_test;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : stop_test

  initial begin
    #1_000_000;
    bad_count++;
    stop_test();
  end

  initial begin
    repeat (16) @(posedge core_clk);
    reset <= 1'b0;
    tick(1);
    t_regs();
    t_root();
    t_inv();
    @(posedge core_clk);
    masterMode <= 1'b0;
    run <= 1'b1;
    rateFamilySelect <= 1'b1;
    chan34Active <= 1'b1;
    t_pdm(1'b0);
    t_pdm(1'b1);
    stop_test();
  end
endmodule : acspc_clock_cfg_tb
